// >>> rtl/htb_break.sv
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "htb_defs.svh"

module htb_break (
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst_b,
  input  wire logic [`HTB_AW-1:0]     i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [31:0]            o_rdata,
  input  wire htb_pkg::htb_tbus_s     i_tbus,
  input  wire logic [`HTB_NEXC-1:0]   i_exc,
  output logic                        o_break,
  output logic                        o_irq
);

  localparam htb_pkg::htb_cfg_s CFG_RST = '{or_en: `HTB_OR_EN_RST,
    comb_en: `HTB_COMB_EN_RST, delay: `HTB_DELAY_RST, default: '0};
  localparam logic [15:0] LOOP_MIN = 16'(`HTB_LOOP_MIN_CYC);

  // =============================================================
  // declarations
  htb_pkg::htb_cfg_s           shd;
  htb_pkg::htb_cfg_s           act;
  htb_pkg::htb_tbus_s          bus_m;
  htb_pkg::htb_tbus_s          bus;
  logic [`HTB_NEXC-1:0]        exc_m;
  logic [`HTB_NEXC-1:0]        exc;
  logic [`HTB_NEV-1:0]         hit;
  logic [`HTB_TA_W-1:0]        pc;
  logic [`HTB_NEV-1:0]         seen;
  logic [2:0]                  step;
  logic [1:0]                  st;
  logic [15:0]                 st_cnt;
  logic [15:0]                 dcnt;
  logic                        busy;
  logic [2:0]                  stat;
  logic [2:0]                  mask;
  logic [`HTB_NPATH-1:0]       pm;
  logic [1:0]                  st_to;
  logic                        st_move;

  // =============================================================
  // register decode
  wire [2:0] win    = i_addr[8:6];
  wire [3:0] idx    = i_addr[5:2];
  wire       w_ctrl = i_wr & (i_addr == `HTB_CTRL);
  wire       w_app  = i_wr & (i_addr == `HTB_APPLY);
  wire       w_dly  = i_wr & (i_addr == `HTB_DELAY);
  wire       w_orm  = i_wr & (i_addr == `HTB_ORMASK);
  wire       w_cm   = i_wr & (i_addr == `HTB_CMASK);
  wire       w_exc  = i_wr & (i_addr == `HTB_EXCEN);
  wire       w_slo  = i_wr & (i_addr == `HTB_SUBLO);
  wire       w_shi  = i_wr & (i_addr == `HTB_SUBHI);
  wire       w_sqe  = i_wr & (i_addr == `HTB_SEQEV);
  wire       w_sqc  = i_wr & (i_addr == `HTB_SEQCFG);
  wire       w_stc  = i_wr & (i_addr == `HTB_STCFG);
  wire       w_spe  = i_wr & (i_addr == `HTB_STPEN);
  wire       w_sto  = i_wr & (i_addr == `HTB_STTMO);
  wire       w_msk  = i_wr & (i_addr == `HTB_MASK);
  wire       r_stat = i_rd & (i_addr == `HTB_STAT);
  wire       p_ok   = idx < 4'(`HTB_NPATH);
  wire       w_stp  = i_wr & (win == `HTB_WIN_STP) & p_ok;
  wire       w_elo  = i_wr & (win == `HTB_WIN_EVLO);
  wire       w_ehi  = i_wr & (win == `HTB_WIN_EVHI);
  wire       w_ecf  = i_wr & (win == `HTB_WIN_EVCFG);

  // =============================================================
  // shadow configuration, written by software
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
      shd <= CFG_RST;
    else
    begin
      if (w_ctrl)
        {shd.mode, shd.comb_en, shd.or_en} <= i_wdata[4:0];
      if (w_dly)
        shd.delay <= i_wdata[15:0];
      if (w_orm)
        shd.or_mask <= i_wdata[15:0];
      if (w_cm)
        shd.cmask <= i_wdata[15:0];
      if (w_exc)
        shd.exc_en <= i_wdata[7:0];
      if (w_slo)
        shd.sub_lo <= i_wdata[23:0];
      if (w_shi)
        shd.sub_hi <= i_wdata[23:0];
      if (w_sqe)
        shd.seq_ev <= i_wdata[23:0];
      if (w_sqc)
        {shd.seq_n, shd.seq_rst_en, shd.seq_rst} <= i_wdata[7:0];
      if (w_stc)
        {shd.st_rst_en, shd.st_rst} <= i_wdata[4:0];
      if (w_spe)
        shd.st_pen <= i_wdata[8:0];
      if (w_sto)
        shd.st_tmo <= i_wdata[15:0];
      if (w_stp)
        shd.st_path[idx] <= i_wdata[7:0];
      if (w_elo)
        shd.ev_lo[idx] <= i_wdata[23:0];
      if (w_ehi)
        shd.ev_hi[idx] <= i_wdata[23:0];
      if (w_ecf)
        shd.ev_cfg[idx] <= i_wdata[2:0];
    end
  end

  // =============================================================
  // active configuration, loaded only on apply
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
      act <= CFG_RST;
    else if (w_app)
      act <= shd;
  end

  // =============================================================
  // target bus and exception inputs, two-stage synchronised
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      bus_m <= '0;
      bus   <= '0;
      exc_m <= '0;
      exc   <= '0;
    end
    else
    begin
      bus_m <= i_tbus;
      bus   <= bus_m;
      exc_m <= i_exc;
      exc   <= exc_m;
    end
  end

  // =============================================================
  // event comparators
  genvar g;
  generate
    for (g = 0; g < `HTB_NEV; g++)
    begin : g_ev
      wire in_rng = (bus.addr >= act.ev_lo[g]) & (bus.addr <= act.ev_hi[g]);
      wire f_ok   = act.ev_cfg[g][`HTB_EC_FETCH] &
                    bus.exec & ~bus.prefetch;
      wire d_ok   = (act.ev_cfg[g][`HTB_EC_RD] & bus.rd) |
                    (act.ev_cfg[g][`HTB_EC_WR] & bus.wr);
      assign hit[g] = in_rng & (f_ok | d_ok);
    end
  endgenerate

  // =============================================================
  // or path and exceptional sources
  wire or_trig  = act.or_en & |(hit & act.or_mask);
  wire exc_trig = |(exc & act.exc_en);

  // =============================================================
  // accumulating and simultaneous and
  wire [`HTB_NEV-1:0] sel_hit  = hit & act.cmask;
  wire [`HTB_NEV-1:0] seen_all = seen | sel_hit;
  wire                cm_any   = |act.cmask;
  wire acc_fire = cm_any & (seen_all == act.cmask);
  wire sim_fire = cm_any & (sel_hit == act.cmask);

  // =============================================================
  // subroutine: executing pc inside range
  wire [`HTB_TA_W-1:0] cur_pc = bus.exec ? bus.addr : pc;
  wire in_sub   = (cur_pc >= act.sub_lo) & (cur_pc <= act.sub_hi);
  wire sub_fire = in_sub & |sel_hit;

  // =============================================================
  // sequencer
  wire [2:0] seq_n    = (act.seq_n == 3'h0) ? 3'h1 :
                        (act.seq_n > 3'(`HTB_NSTEP)) ?
                        3'(`HTB_NSTEP) : act.seq_n;
  wire [3:0] seq_ev   = act.seq_ev[step];
  wire       seq_rhit = act.seq_rst_en & hit[act.seq_rst];
  wire       seq_adv  = hit[seq_ev] & ~seq_rhit;
  wire       seq_last = (step == 3'(seq_n - 3'h1));
  wire       seq_fire = seq_adv & seq_last;

  // =============================================================
  // state transition machine
  generate
    for (g = 0; g < `HTB_NPATH; g++)
    begin : g_path
      assign pm[g] = act.st_pen[g] & (act.st_path[g][1:0] == st) &
                     hit[act.st_path[g][7:4]];
    end
  endgenerate

  always_comb
  begin
    st_to   = st;
    st_move = 1'b0;
    for (int p = `HTB_NPATH - 1; p >= 0; p--)
    begin
      if (pm[p])
      begin
        st_to   = act.st_path[p][3:2];
        st_move = 1'b1;
      end
    end
  end

  wire [15:0] tmo_lim  = (act.st_tmo < LOOP_MIN) ? LOOP_MIN :
                         act.st_tmo;
  wire        st_rhit  = act.st_rst_en & hit[act.st_rst];
  wire        tmo_fire = (act.st_tmo != 16'h0) & (st != 2'h0) &
                         (st_cnt >= tmo_lim) & ~st_rhit;
  wire        st_done  = st_move & ~st_rhit & (st_to == `HTB_ST_FINAL);
  wire        st_fire  = st_done | tmo_fire;

  // =============================================================
  // combiner selection
  wire is_st = (act.mode == htb_pkg::CM_ST);
  wire comb_fire =
    (act.mode == htb_pkg::CM_ACC) ? acc_fire :
    (act.mode == htb_pkg::CM_SIM) ? sim_fire :
    (act.mode == htb_pkg::CM_SUB) ? sub_fire :
    (act.mode == htb_pkg::CM_SEQ) ? seq_fire :
    is_st ? st_fire : 1'b0;
  wire comb_trig = act.comb_en & comb_fire;
  wire trig      = or_trig | comb_trig | exc_trig;

  // =============================================================
  // combiner state
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      pc     <= '0;
      seen   <= '0;
      step   <= 3'h0;
      st     <= 2'h0;
      st_cnt <= 16'h0;
    end
    else if (w_app)
    begin
      seen   <= '0;
      step   <= 3'h0;
      st     <= 2'h0;
      st_cnt <= 16'h0;
    end
    else
    begin
      if (bus.exec)
        pc <= bus.addr;
      seen <= acc_fire ? '0 : seen_all;
      if (seq_rhit | seq_fire)
        step <= 3'h0;
      else if (seq_adv)
        step <= step + 3'h1;
      if (st_rhit | st_fire)
        st <= 2'h0;
      else if (st_move)
        st <= st_to;
      if (st_rhit | st_fire | st_move | (st == 2'h0))
        st_cnt <= 16'h0;
      else if (st_cnt != 16'hffff)
        st_cnt <= st_cnt + 16'h1;
    end
  end

  // =============================================================
  // break delay
  wire brk_now = busy ? (dcnt == 16'h0) : (trig & (act.delay == 16'h0));
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      busy    <= 1'b0;
      dcnt    <= 16'h0;
      o_break <= 1'b0;
    end
    else
    begin
      o_break <= brk_now & ~w_app & ~o_break;
      if (w_app | brk_now)
        busy <= 1'b0;
      else if (busy)
        dcnt <= dcnt - 16'h1;
      else if (trig)
      begin
        busy <= 1'b1;
        dcnt <= act.delay - 16'h1;
      end
    end
  end

  // =============================================================
  // status and interrupt
  wire [2:0] ev_set    = {act.comb_en & is_st & tmo_fire,
                          trig, brk_now & ~w_app};
  wire [2:0] next_stat = (r_stat ? 3'h0 : stat) | ev_set;
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      stat  <= 3'h0;
      mask  <= 3'h0;
      o_irq <= 1'b0;
    end
    else
    begin
      stat  <= next_stat;
      if (w_msk)
        mask <= i_wdata[2:0];
      o_irq <= |(next_stat & (w_msk ? i_wdata[2:0] : mask));
    end
  end

  // =============================================================
  // read data
  wire [31:0] rd_val =
    (i_addr == `HTB_CTRL)   ? {27'h0, shd.mode, shd.comb_en, shd.or_en} :
    (i_addr == `HTB_DELAY)  ? {16'h0, shd.delay} :
    (i_addr == `HTB_ORMASK) ? {16'h0, shd.or_mask} :
    (i_addr == `HTB_CMASK)  ? {16'h0, shd.cmask} :
    (i_addr == `HTB_EXCEN)  ? {24'h0, shd.exc_en} :
    (i_addr == `HTB_SUBLO)  ? {8'h0, shd.sub_lo} :
    (i_addr == `HTB_SUBHI)  ? {8'h0, shd.sub_hi} :
    (i_addr == `HTB_SEQEV)  ? {8'h0, shd.seq_ev} :
    (i_addr == `HTB_SEQCFG) ? {24'h0, shd.seq_n, shd.seq_rst_en, shd.seq_rst} :
    (i_addr == `HTB_STCFG)  ? {27'h0, shd.st_rst_en, shd.st_rst} :
    (i_addr == `HTB_STPEN)  ? {23'h0, shd.st_pen} :
    (i_addr == `HTB_STTMO)  ? {16'h0, shd.st_tmo} :
    (i_addr == `HTB_STAT)   ? {29'h0, stat} :
    (i_addr == `HTB_MASK)   ? {29'h0, mask} :
    (i_addr == `HTB_STATE)  ? {dcnt, 9'h0, busy, st, 1'b0, step} :
    ((win == `HTB_WIN_STP) & p_ok) ? {24'h0, shd.st_path[idx]} :
    (win == `HTB_WIN_EVLO)  ? {8'h0, shd.ev_lo[idx]} :
    (win == `HTB_WIN_EVHI)  ? {8'h0, shd.ev_hi[idx]} :
    (win == `HTB_WIN_EVCFG) ? {29'h0, shd.ev_cfg[idx]} :
    32'h0;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
      o_rdata <= 32'h0;
    else
      o_rdata <= i_rd ? rd_val : 32'h0;
  end

endmodule : htb_break

// >>> rtl/htb_defs.svh
`ifndef HTB_DEFS_SVH
`define HTB_DEFS_SVH

// =============================================================
// widths and counts
`define HTB_NEV        16
`define HTB_EVI_W      4
`define HTB_AW         9
`define HTB_TA_W       24
`define HTB_NSTEP      6
`define HTB_NPATH      9
`define HTB_NEXC       8

// =============================================================
// register offsets (byte addresses)
`define HTB_CTRL       9'h000
`define HTB_APPLY      9'h004
`define HTB_DELAY      9'h008
`define HTB_ORMASK     9'h00c
`define HTB_CMASK      9'h010
`define HTB_EXCEN      9'h014
`define HTB_SUBLO      9'h018
`define HTB_SUBHI      9'h01c
`define HTB_SEQEV      9'h020
`define HTB_SEQCFG     9'h024
`define HTB_STCFG      9'h028
`define HTB_STPEN      9'h02c
`define HTB_STTMO      9'h030
`define HTB_STAT       9'h034
`define HTB_MASK       9'h038
`define HTB_STATE      9'h03c
// windows selected by address bits 8:6, entry by bits 5:2
`define HTB_WIN_STP    3'h1
`define HTB_WIN_EVLO   3'h2
`define HTB_WIN_EVHI   3'h3
`define HTB_WIN_EVCFG  3'h4

// =============================================================
// field positions and final state
`define HTB_EC_FETCH   0
`define HTB_EC_RD      1
`define HTB_EC_WR      2
`define HTB_ST_BRK     0
`define HTB_ST_TRIG    1
`define HTB_ST_TMO     2
`define HTB_ST_FINAL   2'h2

// =============================================================
// reset values
`define HTB_OR_EN_RST   1'h1
`define HTB_COMB_EN_RST 1'h0
`define HTB_DELAY_RST   16'h0000

// =============================================================
// timing
`define HTB_CLK_NS      50
`define HTB_LOOP_MIN_NS 10000
`define HTB_LOOP_MIN_CYC \
  ((`HTB_LOOP_MIN_NS + `HTB_CLK_NS - 1) / `HTB_CLK_NS)

`endif

// >>> rtl/htb_pkg.sv
`include "htb_defs.svh"

package htb_pkg;

  typedef enum logic [2:0] {
    CM_ACC,
    CM_SIM,
    CM_SUB,
    CM_SEQ,
    CM_ST
  } htb_mode_e;

  // one observed target bus cycle
  typedef struct packed {
    logic                 exec;
    logic                 prefetch;
    logic                 rd;
    logic                 wr;
    logic [`HTB_TA_W-1:0] addr;
  } htb_tbus_s;

  typedef struct packed {
    logic                                  or_en;
    logic                                  comb_en;
    logic [2:0]                            mode;
    logic [15:0]                           delay;
    logic [`HTB_NEV-1:0]                   or_mask;
    logic [`HTB_NEV-1:0]                   cmask;
    logic [`HTB_NEXC-1:0]                  exc_en;
    logic [`HTB_TA_W-1:0]                  sub_lo;
    logic [`HTB_TA_W-1:0]                  sub_hi;
    logic [`HTB_NSTEP-1:0][`HTB_EVI_W-1:0] seq_ev;
    logic [`HTB_EVI_W-1:0]                 seq_rst;
    logic                                  seq_rst_en;
    logic [2:0]                            seq_n;
    logic [`HTB_EVI_W-1:0]                 st_rst;
    logic                                  st_rst_en;
    logic [`HTB_NPATH-1:0]                 st_pen;
    logic [`HTB_NPATH-1:0][7:0]            st_path;
    logic [15:0]                           st_tmo;
    logic [`HTB_NEV-1:0][`HTB_TA_W-1:0]    ev_lo;
    logic [`HTB_NEV-1:0][`HTB_TA_W-1:0]    ev_hi;
    logic [`HTB_NEV-1:0][2:0]              ev_cfg;
  } htb_cfg_s;

endpackage : htb_pkg

// >>> sim/htb_break_sva.sv
`timescale 1ns/10ps
`include "htb_defs.svh"

module htb_break_sva (
  input wire logic                 i_sys_clk,
  input wire logic                 i_rst_b,
  input wire logic [`HTB_AW-1:0]   i_addr,
  input wire logic [31:0]          i_wdata,
  input wire logic                 i_wr,
  input wire logic                 i_rd,
  input wire logic [31:0]          o_rdata,
  input wire logic [`HTB_NEXC-1:0] i_exc,
  input wire logic                 o_break,
  input wire logic                 o_irq
);
  // ===========================================================
  // shadow of written and applied settings
  logic                 p_or, p_cmb, a_or, a_cmb, msk;
  logic [15:0]          p_dly, a_dly;
  logic [`HTB_NEXC-1:0] p_exc, a_exc;
  logic [1:0]           since;
  wire w_app = i_wr && (i_addr == `HTB_APPLY);
  wire w_off = !a_or && !a_cmb && (since == 2'h3);

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      {p_or, a_or, p_cmb, a_cmb, msk} <= 5'h18;
      {p_dly, a_dly, p_exc, a_exc, since} <= '0;
    end
    else
    begin
      if (i_wr && i_addr == `HTB_CTRL) {p_cmb, p_or} <= i_wdata[1:0];
      if (i_wr && i_addr == `HTB_DELAY) p_dly <= i_wdata[15:0];
      if (i_wr && i_addr == `HTB_EXCEN) p_exc <= i_wdata[7:0];
      if (i_wr && i_addr == `HTB_MASK) msk <= i_wdata[0];
      if (w_app) {a_or, a_cmb, a_dly, a_exc} <= {p_or, p_cmb, p_dly, p_exc};
      since <= w_app ? 2'h0 : since + {1'b0, since != 2'h3};
    end
  end

  // ===========================================================
  // properties
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_exc_hit;
    (a_dly == 16'h0) && ((i_exc & a_exc) != '0) && !i_wr ##1 !i_wr ##1 !i_wr;
  endsequence

  a_exc_break: assert property (s_exc_hit |=>
    o_break || $past(o_break))
    else $error("enabled exception missed");
  a_exc_gate: assert property (w_off && a_dly == 16'h0 &&
    (($past(i_exc, 3) & a_exc) == '0) |-> !o_break)
    else $error("break from disabled exception");
  a_no_source: assert property (w_off && a_exc == '0 |-> !o_break)
    else $error("break with no source");
  a_break_pulse: assert property (o_break |=> !o_break)
    else $error("break longer than one cycle");
  a_reset_quiet: assert property (disable iff (1'b0) !i_rst_b |=>
    !o_break && !o_irq && o_rdata == 32'h0)
    else $error("outputs active in reset");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data without read");
  a_irq_fall: assert property ($fell(o_irq) |-> $past(i_rd) ||
    $past(i_rd, 2) || $past(i_wr) || $past(i_wr, 2))
    else $error("irq dropped without access");
  a_brk_irq: assert property (o_break && msk |-> ##[0:2] o_irq)
    else $error("masked break gave no irq");
endmodule : htb_break_sva

bind htb_break htb_break_sva i_sva (.i_sys_clk, .i_rst_b, .i_addr, .i_wdata,
  .i_wr, .i_rd, .o_rdata, .i_exc, .o_break, .o_irq);

// >>> sim/htb_cpu_model.sv
`timescale 1ns/10ps
`include "htb_defs.svh"

module htb_cpu_model (
  input  wire logic                 i_sys_clk,
  output htb_pkg::htb_tbus_s        o_tbus,
  output logic [`HTB_NEXC-1:0]      o_exc
);
  initial
  begin
    o_tbus = '0;
    o_exc  = '0;
  end

  // one bus cycle, then idle with inverted address
  task automatic bus(input logic [3:0] k, input logic [23:0] a,
                     input logic [`HTB_NEXC-1:0] x);
    @(posedge i_sys_clk);
    o_tbus <= {k, a};
    o_exc  <= x;
    @(posedge i_sys_clk);
    o_tbus <= {4'h0, ~a};
    o_exc  <= '0;
  endtask : bus
endmodule : htb_cpu_model

// >>> sim/testbench.sv
`timescale 1ns/10ps
`include "htb_defs.svh"

`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("unexpected at %0t: %0h vs %0h", $time, g, e); \
    end \
  end

module testbench;
  typedef struct packed {
    logic [3:0]  kind;
    logic [23:0] addr;
    logic [7:0]  idx;
  } htb_row_s;
  localparam logic [3:0] FE = 4'h8;
  localparam logic [3:0] PF = 4'h4;
  localparam logic [3:0] RD = 4'h2;
  localparam logic [3:0] WR = 4'h1;
  localparam logic [31:0] LO [3] = '{32'h100, 32'h200, 32'h0};
  localparam logic [31:0] HI [3] = '{32'h10f, 32'h2ff, 32'h100};
  localparam logic [31:0] CF [3] = '{32'h1, 32'h2, 32'h1};
  localparam htb_row_s ROWS [9] = '{'{FE, 24'h100, 8'd4},
    '{PF, 24'h100, 8'd0}, '{FE | PF, 24'h100, 8'd0}, '{FE, 24'h0ff, 8'd0},
    '{FE, 24'h10f, 8'd4}, '{FE, 24'h110, 8'd0}, '{RD, 24'h2ff, 8'd4},
    '{WR, 24'h200, 8'd0}, '{RD, 24'h300, 8'd0}};

  logic                 i_sys_clk = 1'b0;
  logic                 i_rst_b = 1'b0;
  logic [`HTB_AW-1:0]   i_addr = '0;
  logic [31:0]          i_wdata = '0;
  logic                 i_wr = 1'b0;
  logic                 i_rd = 1'b0;
  logic [31:0]          o_rdata, d;
  htb_pkg::htb_tbus_s   i_tbus;
  logic [`HTB_NEXC-1:0] i_exc;
  logic                 o_break, o_irq;
  int                   error_cnt = 0, check_count = 0, cyc = 0;

  htb_break i_dut (.i_sys_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_tbus, .i_exc, .o_break, .o_irq);
  htb_cpu_model i_cpu (.i_sys_clk, .o_tbus(i_tbus), .o_exc(i_exc));

  always #25 i_sys_clk = ~i_sys_clk;

  // ===========================================================
  // tasks
  task automatic wrap_up();
    if (error_cnt == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  always @(posedge i_sys_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic wr(input logic [8:0] a, input logic [31:0] v);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [8:0] a, output logic [31:0] v);
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd

  task automatic apply();
    wr(`HTB_APPLY, 32'h0);
  endtask : apply

  task automatic cmode(input logic [2:0] m, input logic [31:0] cm);
    wr(`HTB_CTRL, {27'h0, m, 2'b10});
    wr(`HTB_CMASK, cm);
    apply();
  endtask : cmode

  // one target cycle, index of first break cycle (0 = none)
  task automatic chk_step(input logic [3:0] k, input logic [23:0] a,
                          input logic [7:0] x, input int e);
    int idx;
    idx = 0;
    fork
      i_cpu.bus(k, a, x);
      for (int n = 1; n <= 14; n++)
      begin
        @(posedge i_sys_clk);
        #1;
        if (o_break !== 1'b0 && idx == 0)
          idx = n;
      end
    join
    `CHK(idx, e)
  endtask : chk_step

  // ===========================================================
  // main sequence
  initial
  begin
    repeat (12) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    rd(`HTB_CTRL, d);
    `CHK(d, 32'h1)
    rd(`HTB_DELAY, d);
    `CHK(d, 32'h0)
    rd(9'h140, d);
    `CHK(d, 32'h0)
    for (int e = 0; e < 3; e++)
    begin
      wr(9'h080 + 9'(4 * e), LO[e]);
      wr(9'h0c0 + 9'(4 * e), HI[e]);
      wr(9'h100 + 9'(4 * e), CF[e]);
    end
    wr(`HTB_ORMASK, 32'h3);
    chk_step(FE, 24'h100, 8'h0, 0);
    apply();
    foreach (ROWS[r])
      chk_step(ROWS[r].kind, ROWS[r].addr, 8'h0, int'(ROWS[r].idx));
    wr(`HTB_DELAY, 32'hffff);
    rd(`HTB_DELAY, d);
    `CHK(d, 32'hffff)
    wr(`HTB_DELAY, 32'h5);
    apply();
    chk_step(FE, 24'h100, 8'h0, 9);
    wr(`HTB_DELAY, 32'h0);
    cmode(3'h0, 32'h3);
    chk_step(FE, 24'h100, 8'h0, 0);
    chk_step(RD, 24'h250, 8'h0, 4);
    chk_step(FE, 24'h100, 8'h0, 0);
    apply();
    chk_step(RD, 24'h250, 8'h0, 0);
    cmode(3'h1, 32'h5);
    chk_step(FE, 24'h105, 8'h0, 0);
    chk_step(FE, 24'h0ff, 8'h0, 0);
    chk_step(FE, 24'h100, 8'h0, 4);
    wr(`HTB_SUBLO, 32'h100);
    wr(`HTB_SUBHI, 32'h1ff);
    cmode(3'h2, 32'h2);
    chk_step(FE, 24'h050, 8'h0, 0);
    chk_step(RD, 24'h250, 8'h0, 0);
    chk_step(FE, 24'h180, 8'h0, 0);
    chk_step(RD, 24'h250, 8'h0, 4);
    wr(`HTB_SEQEV, 32'h10);
    wr(`HTB_SEQCFG, 32'h52);
    cmode(3'h3, 32'h7);
    chk_step(RD, 24'h250, 8'h0, 0);
    chk_step(FE, 24'h105, 8'h0, 0);
    chk_step(FE, 24'h0ff, 8'h0, 0);
    chk_step(RD, 24'h250, 8'h0, 0);
    chk_step(FE, 24'h105, 8'h0, 0);
    chk_step(RD, 24'h250, 8'h0, 4);
    wr(9'h040, 32'h04);
    wr(9'h044, 32'h19);
    wr(`HTB_STPEN, 32'h3);
    cmode(3'h4, 32'h7);
    chk_step(RD, 24'h250, 8'h0, 0);
    chk_step(FE, 24'h105, 8'h0, 0);
    chk_step(RD, 24'h250, 8'h0, 4);
    wr(`HTB_STTMO, 32'hc8);
    cmode(3'h4, 32'h7);
    chk_step(FE, 24'h105, 8'h0, 0);
    repeat (150) @(posedge i_sys_clk);
    rd(`HTB_STAT, d);
    `CHK(d[2], 1'b0)
    repeat (60) @(posedge i_sys_clk);
    rd(`HTB_STAT, d);
    `CHK(d[2], 1'b1)
    cmode(3'h5, 32'h7);
    chk_step(FE, 24'h100, 8'h0, 0);
    wr(`HTB_CTRL, 32'h0);
    apply();
    chk_step(FE, 24'h100, 8'h0, 0);
    for (int k = 0; k < `HTB_NEXC; k++)
    begin
      wr(`HTB_EXCEN, 32'(1 << k));
      apply();
      chk_step(4'h0, 24'h0, ~(8'h01 << k), 0);
      chk_step(4'h0, 24'h0, 8'h01 << k, 4);
    end
    wr(`HTB_CTRL, 32'h1);
    apply();
    chk_step(FE, 24'h100, 8'h0, 4);
    chk_step(4'h0, 24'h0, 8'h80, 4);
    wr(`HTB_MASK, 32'h1);
    rd(`HTB_STAT, d);
    chk_step(FE, 24'h100, 8'h0, 4);
    `CHK(o_irq, 1'b1)
    rd(`HTB_STAT, d);
    `CHK(d[0], 1'b1)
    repeat (2) @(posedge i_sys_clk);
    #1 `CHK(o_irq, 1'b0)
    @(posedge i_sys_clk);
    i_rst_b <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    rd(`HTB_CTRL, d);
    `CHK(d, 32'h1)
    rd(`HTB_EXCEN, d);
    `CHK(d, 32'h0)
    wrap_up();
  end
endmodule : testbench
